// *** verilog/apc_pkg.sv ***
// register map, field layouts and reset values of the synthesiser configuration block
// shared by the register file, the divider-apply logic and the top
package apc_pkg;
   localparam logic [7:0] ADDR_DITHER_LOOP   = 8'h43;
   localparam logic [7:0] ADDR_UPDATE_CTRL   = 8'h44;
   localparam logic [7:0] ADDR_SOURCE_POWER  = 8'h45;
   localparam logic [7:0] ADDR_CLOCK_STATUS  = 8'h46;
   localparam logic [7:0] ADDR_FINE_HI       = 8'h41;
   localparam logic [7:0] ADDR_FINE_LO       = 8'h42;

   localparam logic [7:0] RST_DITHER_LOOP    = 8'h00;
   localparam logic [7:0] RST_UPDATE_CTRL    = 8'h00;
   localparam logic [7:0] RST_SOURCE_POWER   = 8'h00;
   localparam logic [7:0] RST_FINE           = 8'h00;

   // field positions
   localparam int DITHER_LSB      = 6;
   localparam int DIV_CHANGE_BIT  = 7;
   localparam int RATIO_TYPE_BIT  = 6;
   localparam int STROBE_BIT      = 5;
   localparam int STROBE_BYP_BIT  = 4;
   localparam int MANUAL_BIT      = 5;
   localparam int PWD_BIT         = 4;
   localparam int BYPASS_BIT      = 3;
   localparam int OSCILLATOR_POWERDOWN_BIT      = 2;
   localparam int BOOST_BIT       = 0;
   localparam int ST_BYPASS_BIT   = 3;
   localparam int ST_PWD_BIT      = 2;
   localparam int ST_OSC_BIT      = 1;
   localparam int ST_FREQ_BIT     = 0;

   // cycles the synthesiser is held down to apply a divider change
   localparam int          RELOCK_NS     = 100;
   localparam int          CLK_NS        = 10;
   localparam logic [3:0]  RELOCK_CYCLES = 4'(RELOCK_NS / CLK_NS);

   typedef enum logic [1:0] {DITHER_OFF, DITHER_TRI, DITHER_RECT, DITHER_RSV} apc_dither_e;

   typedef struct packed {
      logic [15:0] fineRatio;
      logic [3:0]  inputDivider;
      logic [5:0]  loopDivider;
      logic        ratioFractional;
   } apc_div_s;

   typedef struct packed {
      apc_dither_e ditherMode;
      logic        divChangeMode;
      logic        strobeBypass;
      logic        manualConfig;
      logic        synthPowerdown;
      logic        synthBypass;
      logic        oscPowerdown;
      logic        tripleOversample;
   } apc_ctrl_s;
endpackage

// *** verilog/apc_sync2.sv ***
// two-flop synchroniser for a vector of asynchronous levels
// assumes the inputs are quasi-static levels
module apc_sync2 #(
   parameter int W = 4
) (
   input  wire logic         mclk,    // system clock
   input  wire logic         rstSync, // synchronised reset, active low
   input  wire logic         clkEn,   // freezes state when low
   input  wire logic [W-1:0] din,     // asynchronous levels
   output      logic [W-1:0] dout     // synchronised levels
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] dout_nxt;

   always_comb begin
      meta_nxt = clkEn ? din : meta_r;
      dout_nxt = clkEn ? meta_r : dout;
   end

   always_ff @(posedge mclk or negedge rstSync) begin
      if (!rstSync) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= meta_nxt;
         dout   <= dout_nxt;
      end
   end
endmodule

// *** verilog/apc_div_apply.sv ***
// applies pending divider settings to the synthesiser
// assumes pending settings come from the register file on the same clock
module apc_div_apply (
   input  wire logic              mclk,        // system clock
   input  wire logic              rstSync,     // synchronised reset, active low
   input  wire logic              clkEn,       // freezes state when low
   input  wire apc_pkg::apc_div_s pending,     // manual or automatic settings to apply
   input  wire logic              strobe,      // one-cycle apply pulse
   input  wire logic              strobeBypass,// apply without strobe
   input  wire logic              divChangeMode,// 0 = via power-down
   output      apc_pkg::apc_div_s applied,     // settings driving the synthesiser
   output      logic              applyHold    // synthesiser held down for the change
);
   logic              change;
   logic [3:0]        hold_r;
   logic [3:0]        hold_nxt;
   apc_pkg::apc_div_s applied_nxt;

   always_comb begin
      change      = (strobeBypass || strobe) && (pending != applied);
      applied_nxt = applied;
      hold_nxt    = hold_r;
      if (clkEn) begin
         if (hold_r != 4'h0)
            hold_nxt = hold_r - 4'h1;
         if (change) begin
            applied_nxt = pending;
            if (!divChangeMode)
               hold_nxt = apc_pkg::RELOCK_CYCLES;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync) begin
      if (!rstSync) begin
         applied <= '0;
         hold_r  <= 4'h0;
      end else begin
         applied <= applied_nxt;
         hold_r  <= hold_nxt;
      end
   end

   assign applyHold = (hold_r != 4'h0);
endmodule

// *** verilog/apc_top.sv ***
// register file and control of the audio clock synthesiser
// assumes a byte-wide register port in the mclk domain; analog status arrives asynchronously
// What this block does
// - dither field picks off, triangular or rectangular dither; code 11 reserved
// - divider change mode 0 applies changes through a synthesiser power-down
// - ratio type 0 integer, 1 fractional using the fine ratio word
// - divider strobe applies pending divider changes synchronously
// - strobe bypass 1 lets divider changes take effect without strobe
// - manual bit picks register fields, otherwise master clock select
// - power-down bit 1 puts the synthesiser into power-down
// - bypass bit 1 drives the system clock from the external pin
// - oscillator power-down bit 1 stops the internal oscillator
// - boost bit forces oversampling to three, otherwise input rate bits
// - status bits: bypass 3, power-down 2, oscillator lock 1, frequency check 0
// - manual output frequency: input times loop/(input+1) plus fine/65536
// - automatic configuration by default until manual bit is set
module apc_top (
   input  wire logic        mclk,              // system clock, 100 MHz
   input  wire logic        rst_n,             // asynchronous reset, active low
   input  wire logic        clkEn,             // freezes all state except the reset synchroniser when low
   input  wire logic [7:0]  regAddr,           // register address
   input  wire logic [7:0]  regWdata,          // write data
   input  wire logic        regWrite,          // write strobe
   input  wire logic        regRead,           // read strobe
   output      logic [7:0]  regRdata,          // read data
   input  wire logic [3:0]  masterClockSelect, // automatic setting selector
   input  wire logic [1:0]  inputRateBits,     // input rate oversampling select
   input  wire logic        oscLockAsync,      // oscillator lock, asynchronous
   input  wire logic        freqCheckAsync,    // input frequency check, asynchronous
   input  wire logic        synthBypassAsync,  // live bypass state, asynchronous
   input  wire logic        synthDownAsync,    // live power-down state, asynchronous
   output      logic [15:0] synthFine,         // fine ratio word to synthesiser
   output      logic [3:0]  synthInDiv,        // input divider to synthesiser
   output      logic [5:0]  synthLoopDiv,      // loop divider to synthesiser
   output      logic        synthFractional,   // fractional ratio enable
   output      logic [1:0]  synthDither,       // dither mode to synthesiser
   output      logic        synthPowerdown,    // synthesiser power-down
   output      logic        sysClkFromPin,     // system clock mux select
   output      logic        oscillatorPowerdown, // internal oscillator power-down
   output      logic [1:0]  oversampleFactor   // oversampling select, 3 = forced x3
);
   // reset release
   logic rstMeta_r;
   logic rstSync;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'b0;
         rstSync   <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync   <= rstMeta_r;
      end
   end

   logic [7:0] fineHi_r, fineHi_nxt;
   logic [7:0] fineLo_r, fineLo_nxt;
   logic [7:0] ditherLoop_r, ditherLoop_nxt;
   logic [7:0] updateCtrl_r, updateCtrl_nxt;
   logic [7:0] sourcePower_r, sourcePower_nxt;
   logic       strobePulse;
   logic [7:0] rdata_nxt;
   logic [3:0] liveSync;
   apc_pkg::apc_ctrl_s ctrl;
   apc_pkg::apc_div_s  manualDiv;
   apc_pkg::apc_div_s  autoDiv;
   apc_pkg::apc_div_s  pendingDiv;
   apc_pkg::apc_div_s  appliedDiv;
   logic       applyHold;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   always_comb begin
      fineHi_nxt      = fineHi_r;
      fineLo_nxt      = fineLo_r;
      ditherLoop_nxt  = ditherLoop_r;
      updateCtrl_nxt  = updateCtrl_r;
      sourcePower_nxt = sourcePower_r;
      strobePulse     = 1'b0;
      if (clkEn && regWrite) begin
         if (hit(regAddr, apc_pkg::ADDR_FINE_HI))
            fineHi_nxt = regWdata;
         if (hit(regAddr, apc_pkg::ADDR_FINE_LO))
            fineLo_nxt = regWdata;
         if (hit(regAddr, apc_pkg::ADDR_DITHER_LOOP))
            ditherLoop_nxt = regWdata;
         if (hit(regAddr, apc_pkg::ADDR_UPDATE_CTRL)) begin
            updateCtrl_nxt = regWdata & ~(8'h01 << apc_pkg::STROBE_BIT);
            strobePulse    = regWdata[apc_pkg::STROBE_BIT];
         end
         if (hit(regAddr, apc_pkg::ADDR_SOURCE_POWER))
            sourcePower_nxt = regWdata & 8'h3D;
      end
   end

   always_ff @(posedge mclk or negedge rstSync) begin
      if (!rstSync) begin
         fineHi_r      <= apc_pkg::RST_FINE;
         fineLo_r      <= apc_pkg::RST_FINE;
         ditherLoop_r  <= apc_pkg::RST_DITHER_LOOP;
         updateCtrl_r  <= apc_pkg::RST_UPDATE_CTRL;
         sourcePower_r <= apc_pkg::RST_SOURCE_POWER;
      end else begin
         fineHi_r      <= fineHi_nxt;
         fineLo_r      <= fineLo_nxt;
         ditherLoop_r  <= ditherLoop_nxt;
         updateCtrl_r  <= updateCtrl_nxt;
         sourcePower_r <= sourcePower_nxt;
      end
   end

   always_comb begin
      ctrl.ditherMode       = apc_pkg::apc_dither_e'(ditherLoop_r[apc_pkg::DITHER_LSB +: 2]);
      ctrl.divChangeMode    = updateCtrl_r[apc_pkg::DIV_CHANGE_BIT];
      ctrl.strobeBypass     = updateCtrl_r[apc_pkg::STROBE_BYP_BIT];
      ctrl.manualConfig     = sourcePower_r[apc_pkg::MANUAL_BIT];
      ctrl.synthPowerdown   = sourcePower_r[apc_pkg::PWD_BIT];
      ctrl.synthBypass      = sourcePower_r[apc_pkg::BYPASS_BIT];
      ctrl.oscPowerdown     = sourcePower_r[apc_pkg::OSCILLATOR_POWERDOWN_BIT];
      ctrl.tripleOversample = sourcePower_r[apc_pkg::BOOST_BIT];
   end

   always_comb begin
      manualDiv.fineRatio       = {fineHi_r, fineLo_r};
      manualDiv.inputDivider    = updateCtrl_r[3:0];
      manualDiv.loopDivider     = ditherLoop_r[5:0];
      manualDiv.ratioFractional = updateCtrl_r[apc_pkg::RATIO_TYPE_BIT];
      // automatic: integer ratio, loop divider is 8 plus the selector
      autoDiv.fineRatio       = 16'h0000;
      autoDiv.inputDivider    = 4'h0;
      autoDiv.loopDivider     = 6'h08 + {2'h0, masterClockSelect};
      autoDiv.ratioFractional = 1'b0;
      pendingDiv = ctrl.manualConfig ? manualDiv : autoDiv;
   end

   apc_div_apply u_apply (
      .mclk          (mclk),
      .rstSync       (rstSync),
      .clkEn         (clkEn),
      .pending       (pendingDiv),
      .strobe        (strobePulse),
      .strobeBypass  (ctrl.strobeBypass | ~ctrl.manualConfig),
      .divChangeMode (ctrl.divChangeMode),
      .applied       (appliedDiv),
      .applyHold     (applyHold)
   );

   apc_sync2 #(.W(4)) u_sync (
      .mclk    (mclk),
      .rstSync (rstSync),
      .clkEn   (clkEn),
      .din     ({synthBypassAsync, synthDownAsync, oscLockAsync, freqCheckAsync}),
      .dout    (liveSync)
   );

   // fine word only reaches the synthesiser in fractional mode
   assign synthFine       = appliedDiv.ratioFractional ? appliedDiv.fineRatio : 16'h0000;
   assign synthInDiv      = appliedDiv.inputDivider;
   assign synthLoopDiv    = appliedDiv.loopDivider;
   assign synthFractional = appliedDiv.ratioFractional;
   assign synthDither     = (ctrl.ditherMode == apc_pkg::DITHER_RSV) ? 2'h0 : ctrl.ditherMode;
   assign synthPowerdown  = ctrl.synthPowerdown | applyHold;
   assign sysClkFromPin   = ctrl.synthBypass;
   assign oscillatorPowerdown = ctrl.oscPowerdown;
   assign oversampleFactor = ctrl.tripleOversample ? 2'h3 : inputRateBits;

   always_comb begin
      rdata_nxt = regRdata;
      if (clkEn && regRead) begin
         unique case (1'b1)
            hit(regAddr, apc_pkg::ADDR_FINE_HI):      rdata_nxt = fineHi_r;
            hit(regAddr, apc_pkg::ADDR_FINE_LO):      rdata_nxt = fineLo_r;
            hit(regAddr, apc_pkg::ADDR_DITHER_LOOP):  rdata_nxt = ditherLoop_r;
            hit(regAddr, apc_pkg::ADDR_UPDATE_CTRL):  rdata_nxt = updateCtrl_r;
            hit(regAddr, apc_pkg::ADDR_SOURCE_POWER): rdata_nxt = sourcePower_r;
            hit(regAddr, apc_pkg::ADDR_CLOCK_STATUS): rdata_nxt = {4'h0, liveSync};
            default:                         rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstSync) begin
      if (!rstSync)
         regRdata <= 8'h00;
      else
         regRdata <= rdata_nxt;
   end
endmodule

// *** sim/apc_top_asserts.sv ***
// port assertions of the synthesiser configuration block
// bound to apc_top below; one mclk domain
module apc_top_asserts (
   input wire logic       mclk,                // clock
   input wire logic       rst_n,               // reset, low
   input wire logic       clkEn,               // enable
   input wire logic [7:0] regAddr,             // address
   input wire logic [7:0] regWdata,            // write data
   input wire logic       regWrite,            // write strobe
   input wire logic       regRead,             // read strobe
   input wire logic [7:0] regRdata,            // read data
   input wire logic [1:0] inputRateBits,       // rate bits
   input wire logic [1:0] synthDither,         // dither
   input wire logic       synthPowerdown,      // power-down
   input wire logic       sysClkFromPin,       // bypass
   input wire logic       oscillatorPowerdown, // osc off
   input wire logic [1:0] oversampleFactor     // oversampling
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr43, wr45, rd46;
   assign wr43 = regWrite && clkEn && regAddr == 8'h43;
   assign wr45 = regWrite && clkEn && regAddr == 8'h45;
   assign rd46 = regRead && clkEn && regAddr == 8'h46;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   dither_map_a: assert property (wr43 |=>
      synthDither == ($past(regWdata[7:6]) == 2'h3 ? 2'h0 : $past(regWdata[7:6]))) else $error("dither wrong");
   powerdown_set_a: assert property (wr45 && regWdata[4] |=> synthPowerdown)
      else $error("power-down not set");
   bypass_write_a: assert property (wr45 |=> sysClkFromPin == $past(regWdata[3]))
      else $error("bypass wrong");
   osc_write_a: assert property (wr45 |=> oscillatorPowerdown == $past(regWdata[2]))
      else $error("oscillator wrong");
   boost_force_a: assert property (wr45 |=>
      oversampleFactor == ($past(regWdata[0]) ? 2'h3 : inputRateBits)) else $error("oversampling wrong");
   status_rsv_a: assert property (rd46 |=> regRdata[7:4] == 4'h0)
      else $error("status high bits set");
   rdata_hold_a: assert property (!(regRead && clkEn) |=> $stable(regRdata))
      else $error("read data moved");
   frozen_state_a: assert property (!clkEn |=> $stable({synthDither, sysClkFromPin, oscillatorPowerdown}))
      else $error("state moved while frozen");
   strobe_c: cover property (regWrite && clkEn && regAddr == 8'h44 && regWdata[5]);
   hold_c: cover property ($rose(synthPowerdown));
   status_c: cover property (rd46);
endmodule
bind apc_top apc_top_asserts apc_top_asserts_inst (.mclk, .rst_n, .clkEn, .regAddr, .regWdata, .regWrite,
   .regRead, .regRdata, .inputRateBits, .synthDither, .synthPowerdown, .sysClkFromPin, .oscillatorPowerdown,
   .oversampleFactor);

// *** sim/apc_synth_model.sv ***
// analog side of the synthesiser: status levels from the controls
// fed by apc_top outputs; lock settles slowest
module apc_synth_model (
   input  wire logic synthPowerdown,      // power-down
   input  wire logic sysClkFromPin,       // bypass
   input  wire logic oscillatorPowerdown, // osc off
   input  wire logic lowClk,              // frequency check
   output      logic oscLockAsync,        // locked
   output      logic freqCheckAsync,      // check result
   output      logic synthBypassAsync,    // bypass state
   output      logic synthDownAsync       // down state
);
   timeunit 1ns;
   timeprecision 1ps;
   assign #3 synthDownAsync = synthPowerdown;
   assign #3 synthBypassAsync = sysClkFromPin;
   assign #25 oscLockAsync = !oscillatorPowerdown;
   assign freqCheckAsync = lowClk;
endmodule

// *** sim/apc_top_tb.sv ***
// self-checking bench of apc_top with the analog status model
// checker arrives by bind; inputs change on falling edges
module apc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic wr; logic [7:0] a, d, e;} apc_row_s;
   logic        mclk = 1'b0;
   logic        rst_n, clkEn, regWrite, regRead, lowClk, synthFractional, synthPowerdown, sysClkFromPin;
   logic        oscillatorPowerdown, oscLockAsync, freqCheckAsync, synthBypassAsync, synthDownAsync;
   logic [7:0]  regAddr, regWdata, regRdata, rdv;
   logic [3:0]  masterClockSelect, synthInDiv;
   logic [1:0]  inputRateBits, synthDither, oversampleFactor;
   logic [15:0] synthFine;
   logic [5:0]  synthLoopDiv;
   int          err_total = 0;
   int          samples_checked = 0;
   int          n;
   // status right after reset: automatic apply hold still shows, oscillator already locked
   apc_row_s    rows [11] = '{'{1'h0, 8'h43, 8'h00, 8'h00}, '{1'h0, 8'h44, 8'h00, 8'h00},
      '{1'h0, 8'h45, 8'h00, 8'h00}, '{1'h0, 8'h41, 8'h00, 8'h00}, '{1'h0, 8'h42, 8'h00, 8'h00},
      '{1'h0, 8'h46, 8'h00, 8'h06}, '{1'h1, 8'h43, 8'hA7, 8'hA7}, '{1'h1, 8'h44, 8'h3F, 8'h1F},
      '{1'h1, 8'h45, 8'hFF, 8'h3D}, '{1'h1, 8'h41, 8'h12, 8'h12}, '{1'h1, 8'h50, 8'hAA, 8'h00}};
   apc_top apc_top_inst (.mclk, .rst_n, .clkEn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .masterClockSelect, .inputRateBits, .oscLockAsync, .freqCheckAsync, .synthBypassAsync, .synthDownAsync,
      .synthFine, .synthInDiv, .synthLoopDiv, .synthFractional, .synthDither, .synthPowerdown, .sysClkFromPin,
      .oscillatorPowerdown, .oversampleFactor);
   apc_synth_model apc_synth_model_inst (.synthPowerdown, .sysClkFromPin, .oscillatorPowerdown, .lowClk,
      .oscLockAsync, .freqCheckAsync, .synthBypassAsync, .synthDownAsync);
   always #5 mclk = ~mclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   // strobes drop one cycle before return, so calls may follow directly
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      regAddr = a;
      regWdata = v;
      regWrite = 1'b1;
      @(negedge mclk);
      regWrite = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [7:0] a);
      regAddr = a;
      regRead = 1'b1;
      @(negedge mclk);
      regRead = 1'b0;
      rdv = regRdata;
      @(negedge mclk);
   endtask
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      repeat (3) @(negedge mclk);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clkEn = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      masterClockSelect = 4'h3;
      inputRateBits = 2'h2;
      lowClk = 1'b0;
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk(rdv, rows[i].e, "register row");
      end
      $display("register table test done");
      do_reset();
      chk({synthInDiv, synthLoopDiv, synthFractional}, {4'h0, 6'h0B, 1'b0}, "auto setting");
      wr(8'h45, 8'h20);
      wr(8'h41, 8'h12);
      wr(8'h42, 8'h34);
      for (int c = 0; c < 4; c++) begin
         wr(8'h43, {2'(c), 6'h14});
         chk(synthDither, (c == 3) ? 2'h0 : 2'(c), "dither mode");
      end
      wr(8'h44, 8'h42);
      chk(synthLoopDiv, 6'h0B, "applied before strobe");
      regWdata = 8'h62;
      regWrite = 1'b1;
      @(negedge mclk);
      regWrite = 1'b0;
      n = 0;
      repeat (30) begin
         if (synthPowerdown === 1'b1) n++;
         @(negedge mclk);
      end
      chk(n, apc_pkg::RELOCK_CYCLES, "hold cycles");
      chk({synthFine, synthInDiv, synthLoopDiv, synthFractional}, {16'h1234, 4'h2, 6'h14, 1'b1}, "strobed");
      wr(8'h44, 8'h91);
      n = 0;
      repeat (5) begin
         if (synthPowerdown === 1'b1) n++;
         @(negedge mclk);
      end
      chk(n, 0, "hold in direct mode");
      chk({synthInDiv, synthLoopDiv, synthFractional}, {4'h1, 6'h14, 1'b0}, "no strobe");
      $display("divider update test done");
      lowClk = 1'b1;
      wr(8'h45, 8'h1C);
      repeat (6) @(negedge mclk);
      chk({synthPowerdown, sysClkFromPin, oscillatorPowerdown}, 3'h7, "controls");
      rd(8'h46);
      chk(rdv, 8'h0D, "status");
      wr(8'h46, 8'hFF);
      rd(8'h46);
      chk(rdv, 8'h0D, "status after write");
      masterClockSelect = 4'h5;
      wr(8'h45, 8'h00);
      repeat (6) @(negedge mclk);
      rd(8'h46);
      chk(rdv, 8'h03, "status restored");
      chk({synthLoopDiv, oversampleFactor}, {6'h0D, 2'h2}, "auto and rate bits");
      wr(8'h45, 8'h01);
      chk(oversampleFactor, 2'h3, "forced x3");
      $display("status and source test done");
      clkEn = 1'b0;
      wr(8'h45, 8'h08);
      clkEn = 1'b1;
      chk(sysClkFromPin, 1'b0, "write while frozen");
      $display("freeze test done");
      test_done();
   end
endmodule
